/* hdl/cec_buffer_addr_wakeup.sv */
`timescale 1ns/1ps

// ****************************************************************
// generic valid/ready fifo
// ****************************************************************
module cec_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_r;
  logic [PW-1:0]    rdPtr_r;
  logic [PW:0]      count_r;
  logic             push;
  logic             pop;

  assign inReady  = (count_r != DEPTH[PW:0]);
  assign outValid = (count_r != '0);
  assign outData  = mem[rdPtr_r];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // storage has no reset; only the pointers matter
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  // pointers wrap by hand so any depth works
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= (wrPtr_r == PW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= (rdPtr_r == PW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
      end
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : cec_fifo

// ****************************************************************
// frame buffers, address map and wake-up detector
// ****************************************************************
module cec_buffer_addr_wakeup #(
  parameter int FIFO_DEPTH = cec_pkg::FIFO_DEPTH
) (
  input  wire logic                        core_clk,
  input  wire logic                        resetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [cec_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        rxValid,
  output logic                             rxReady,
  input  wire cec_pkg::rx_item_type        rxItem,
  output logic                             nackAll,
  output logic      [15:0]                 ownedAddr,
  output logic                             txStart,
  output logic      [cec_pkg::LEN_W-1:0]   txLength,
  input  wire logic [cec_pkg::BUF_AW-1:0]  txIndex,
  output logic      [7:0]                  txByte,
  input  wire logic                        txDone,
  output logic                             wakeEvent
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0]                 txBuf_r [16];
  logic [7:0]                 rxBuf_r [16];
  logic [7:0]                 addrLow_r;
  logic [7:0]                 addrHi_r;
  logic [cec_pkg::LEN_W-1:0]  txLen_r;
  logic [cec_pkg::LEN_W-1:0]  rxLen_r;
  logic [cec_pkg::LEN_W-1:0]  rxPos_r;
  logic                       send_r;
  logic                       lock_r;
  logic                       wakeStat_r;
  logic                       wakeCheck_r;
  logic [7:0]                 wakeEn_r;
  logic [7:0]                 mask_r;
  logic [31:0]                prdata_r;
  logic                       pready_r;
  logic                       pslverr_r;
  logic [7:0]                 txByte_r;
  logic                       wakeEvent_r;
  logic [15:0]                ownedAddr_r;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic [15:0]          regIdx;
  logic                 busWr;
  logic                 busAccess;
  logic                 inTx;
  logic                 inRx;
  logic                 mapped;
  logic [7:0]           wByte;
  logic                 fifoValid;
  logic                 fifoTake;
  cec_pkg::rx_item_type fifoItem;
  logic [7:0]           wakeHits;

  assign regIdx    = paddr[cec_pkg::ADDR_W-1:cec_pkg::IDX_LSB];
  assign busAccess = psel && penable && pready_r;
  assign busWr     = busAccess && pwrite && mapped;
  assign wByte     = pwdata[7:0];
  assign inTx      = (regIdx[15:cec_pkg::BUF_AW] == cec_pkg::IDX_TX_BUF[15:cec_pkg::BUF_AW]);
  assign inRx      = (regIdx[15:cec_pkg::BUF_AW] == cec_pkg::IDX_RX_BUF[15:cec_pkg::BUF_AW]);
  assign mapped    = inTx || inRx ||
                     regIdx == cec_pkg::IDX_CTRL || regIdx == cec_pkg::IDX_STATUS ||
                     regIdx == cec_pkg::IDX_MASK || regIdx == cec_pkg::IDX_ADDR_LOW ||
                     regIdx == cec_pkg::IDX_ADDR_HI || regIdx == cec_pkg::IDX_TX_LEN ||
                     regIdx == cec_pkg::IDX_RX_LEN || regIdx == cec_pkg::IDX_LOCK ||
                     regIdx == cec_pkg::IDX_WAKE_EN;

  // one wait state so read data leaves a flip-flop
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && !mapped;
    end
  end

  // read mux, sampled in the wait cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prdata_r <= '0;
    end else if (psel && penable && !pready_r) begin
      prdata_r <= '0;
      if (inTx) begin
        prdata_r[7:0] <= txBuf_r[regIdx[cec_pkg::BUF_AW-1:0]];
      end else if (inRx) begin
        prdata_r[7:0] <= rxBuf_r[regIdx[cec_pkg::BUF_AW-1:0]];
      end else begin
        unique case (regIdx)
          cec_pkg::IDX_CTRL:     prdata_r[cec_pkg::SEND_BIT] <= send_r;
          cec_pkg::IDX_STATUS:   prdata_r[cec_pkg::WAKE_STAT_BIT] <= wakeStat_r;
          cec_pkg::IDX_MASK:     prdata_r[7:0] <= mask_r;
          cec_pkg::IDX_ADDR_LOW: prdata_r[7:0] <= addrLow_r;
          cec_pkg::IDX_ADDR_HI:  prdata_r[7:0] <= addrHi_r;
          cec_pkg::IDX_TX_LEN:   prdata_r[cec_pkg::LEN_W-1:0] <= txLen_r;
          cec_pkg::IDX_RX_LEN:   prdata_r[cec_pkg::LEN_W-1:0] <= rxLen_r;
          cec_pkg::IDX_LOCK:     prdata_r[cec_pkg::LOCK_BIT] <= lock_r;
          cec_pkg::IDX_WAKE_EN:  prdata_r[7:0] <= wakeEn_r;
          default:               prdata_r <= '0;
        endcase
      end
    end
  end

  // ****************************************************************
  // software-owned configuration
  // ****************************************************************
  // address map, mask and wake enables
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      addrLow_r <= cec_pkg::ADDR_LOW_RST;
      addrHi_r  <= cec_pkg::ADDR_HI_RST;
      wakeEn_r  <= cec_pkg::WAKE_EN_RST;
      mask_r    <= cec_pkg::MASK_RST;
    end else if (busWr) begin
      if (regIdx == cec_pkg::IDX_ADDR_LOW) addrLow_r <= wByte;
      if (regIdx == cec_pkg::IDX_ADDR_HI)  addrHi_r <= wByte;
      if (regIdx == cec_pkg::IDX_WAKE_EN)  wakeEn_r <= wByte;
      if (regIdx == cec_pkg::IDX_MASK)     mask_r <= wByte;
    end
  end

  // transmit length: only software changes it, so it survives every frame
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      txLen_r <= cec_pkg::LEN_ZERO;
    end else if (busWr && regIdx == cec_pkg::IDX_TX_LEN) begin
      // values whose low five bits exceed sixteen are clipped to sixteen, the engine cannot send them
      txLen_r <= (wByte[cec_pkg::LEN_W-1:0] > cec_pkg::FRAME_MAX) ?
                 cec_pkg::FRAME_MAX : wByte[cec_pkg::LEN_W-1:0];
    end
  end

  // transmit buffer, byte-wide per word
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 16; i++) begin
        txBuf_r[i] <= 8'h00;
      end
    end else if (busWr && inTx) begin
      txBuf_r[regIdx[cec_pkg::BUF_AW-1:0]] <= wByte;
    end
  end

  // send request; completion clears it, a zero-length request never sets it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      send_r <= 1'b0;
    end else if (busWr && regIdx == cec_pkg::IDX_CTRL && wByte[cec_pkg::SEND_BIT] &&
                 !send_r && txLen_r != cec_pkg::LEN_ZERO) begin
      send_r <= 1'b1;
    end else if (txDone) begin
      send_r <= 1'b0;
    end
  end

  // ****************************************************************
  // receive path
  // ****************************************************************
  cec_fifo #(
    .WIDTH (cec_pkg::RX_ITEM_W),
    .DEPTH (FIFO_DEPTH)
  ) rxFifo (
    .core_clk (core_clk),
    .resetn   (resetn),
    .inValid  (rxValid),
    .inReady  (rxReady),
    .inData   (rxItem),
    .outValid (fifoValid),
    .outReady (fifoTake),
    .outData  (fifoItem)
  );

  // draining stops while locked, so the stored frame stays intact
  assign fifoTake = fifoValid && !lock_r && !wakeCheck_r;

  // bytes land in the buffer; a bad frame is dropped by rewinding
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rxPos_r <= cec_pkg::LEN_ZERO;
      for (int i = 0; i < 16; i++) begin
        rxBuf_r[i] <= 8'h00;
      end
    end else if (fifoTake) begin
      if (rxPos_r < cec_pkg::FRAME_MAX) begin
        rxBuf_r[rxPos_r[cec_pkg::BUF_AW-1:0]] <= fifoItem.data;
      end
      if (fifoItem.last) begin
        rxPos_r <= cec_pkg::LEN_ZERO;
      end else if (rxPos_r < cec_pkg::FRAME_MAX) begin
        rxPos_r <= rxPos_r + 1'b1;
      end
    end
  end

  // length and lock only on a clean whole frame; set beats software clear
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rxLen_r     <= cec_pkg::LEN_ZERO;
      lock_r      <= 1'b0;
      wakeCheck_r <= 1'b0;
    end else begin
      wakeCheck_r <= 1'b0;
      if (fifoTake && fifoItem.last && fifoItem.good) begin
        rxLen_r     <= (rxPos_r < cec_pkg::FRAME_MAX) ? rxPos_r + 1'b1 : cec_pkg::FRAME_MAX;
        lock_r      <= 1'b1;
        wakeCheck_r <= 1'b1;
      end else if (busWr && regIdx == cec_pkg::IDX_LOCK) begin
        lock_r <= wByte[cec_pkg::LOCK_BIT];
      end
    end
  end

  // ****************************************************************
  // wake-up detector
  // ****************************************************************
  for (genvar g = 0; g < cec_pkg::NUM_OPCODES; g++) begin : gWake
    assign wakeHits[g] = wakeEn_r[g] &&
                         (rxBuf_r[cec_pkg::OPCODE_IDX[cec_pkg::BUF_AW-1:0]] ==
                          cec_pkg::WAKE_OPCODES[g]);
  end

  // result re-evaluated for every clean frame; a header-only frame has no opcode
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wakeStat_r <= 1'b0;
    end else if (wakeCheck_r) begin
      wakeStat_r <= (rxLen_r > cec_pkg::OPCODE_IDX) && (|wakeHits);
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      txByte_r    <= 8'h00;
      wakeEvent_r <= 1'b0;
      ownedAddr_r <= {cec_pkg::ADDR_HI_RST, cec_pkg::ADDR_LOW_RST};
    end else begin
      txByte_r    <= txBuf_r[txIndex];
      wakeEvent_r <= wakeStat_r && !mask_r[cec_pkg::WAKE_STAT_BIT];
      ownedAddr_r <= {addrHi_r, addrLow_r};
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign nackAll   = lock_r;
  assign ownedAddr = ownedAddr_r;
  assign txStart   = send_r;
  assign txLength  = txLen_r;
  assign txByte    = txByte_r;
  assign wakeEvent = wakeEvent_r;

endmodule : cec_buffer_addr_wakeup

/* shared/cec_pkg.sv */
package cec_pkg;

  // ****************************************************************
  // register indices; the byte address on the bus is four times each
  // ****************************************************************
  localparam logic [15:0] IDX_CTRL     = 16'h7d00;
  localparam logic [15:0] IDX_STATUS   = 16'h7d01;
  localparam logic [15:0] IDX_MASK     = 16'h7d02;
  localparam logic [15:0] IDX_ADDR_LOW = 16'h7d05;
  localparam logic [15:0] IDX_ADDR_HI  = 16'h7d06;
  localparam logic [15:0] IDX_TX_LEN   = 16'h7d07;
  localparam logic [15:0] IDX_RX_LEN   = 16'h7d08;
  localparam logic [15:0] IDX_TX_BUF   = 16'h7d10;
  localparam logic [15:0] IDX_RX_BUF   = 16'h7d20;
  localparam logic [15:0] IDX_LOCK     = 16'h7d30;
  localparam logic [15:0] IDX_WAKE_EN  = 16'h7d31;
  localparam int          IDX_LSB      = 2;
  localparam int          ADDR_W       = 18;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int         SEND_BIT      = 0;
  localparam int         LOCK_BIT      = 0;
  localparam int         WAKE_STAT_BIT = 6;
  localparam int         LEN_W         = 5;
  localparam int         BUF_AW        = 4;
  localparam logic [4:0] FRAME_MAX     = 5'd16;
  localparam logic [4:0] OPCODE_IDX    = 5'd1;
  localparam logic [4:0] LEN_ZERO      = 5'd0;
  localparam logic [7:0] ADDR_LOW_RST  = 8'h00;
  localparam logic [7:0] ADDR_HI_RST   = 8'h80;
  localparam logic [7:0] WAKE_EN_RST   = 8'hff;
  localparam logic [7:0] MASK_RST      = 8'h00;
  localparam int         NUM_OPCODES   = 8;

  // opcodes that may wake the system, one per enable bit
  localparam logic [7:0] WAKE_OPCODES [NUM_OPCODES] = '{
    8'h04, 8'h0d, 8'h41, 8'h42, 8'h44, 8'h70, 8'h82, 8'h86
  };

  // ****************************************************************
  // received byte as the line engine hands it over
  // ****************************************************************
  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic       good;
  } rx_item_type;

  localparam int RX_ITEM_W = $bits(rx_item_type);
  localparam int FIFO_DEPTH = 8;

endpackage : cec_pkg

/* verif/cec_buffer_addr_wakeup_checker.sv */
`timescale 1ns/1ps
// ****************
// port checker
// ****************
module cec_buffer_addr_wakeup_checker (
  input wire logic                       core_clk,
  input wire logic                       resetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [cec_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                pwdata,
  input wire logic                       pready,
  input wire logic                       nackAll,
  input wire logic [15:0]                ownedAddr,
  input wire logic                       txStart,
  input wire logic [cec_pkg::LEN_W-1:0]  txLength,
  input wire logic                       txDone
);
  logic        wr;
  logic [15:0] idx;
  // completed write and the index it hits
  assign wr = psel && penable && pready && pwrite;
  assign idx = paddr[17:2];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  addr_reset_a: assert property (
    $rose(resetn) |-> ownedAddr == 16'h8000) else $error("address map reset value wrong");
  // the map port is a second flop behind the register, so it shows a write two edges later
  addr_low_a: assert property (
    wr && idx == cec_pkg::IDX_ADDR_LOW |-> ##2 ownedAddr[7:0] == $past(pwdata[7:0], 2))
    else $error("low map not loaded");
  addr_high_a: assert property (
    wr && idx == cec_pkg::IDX_ADDR_HI |-> ##2 ownedAddr[15:8] == $past(pwdata[7:0], 2))
    else $error("high map not loaded");
  len_max_a: assert property (
    txLength <= 5'h10) else $error("transmit length above sixteen");
  len_hold_a: assert property (
    !(wr && idx == cec_pkg::IDX_TX_LEN) |=> $stable(txLength)) else $error("transmit length moved");
  send_zero_a: assert property (
    wr && idx == cec_pkg::IDX_CTRL && pwdata[0] && txLength == 5'h0 && !txStart |=> !txStart)
    else $error("send accepted with zero length");
  send_set_a: assert property (
    wr && idx == cec_pkg::IDX_CTRL && pwdata[0] && txLength != 5'h0 && !txStart |=> txStart)
    else $error("send not started");
  send_clear_a: assert property (
    txStart && txDone |=> !txStart) else $error("send bit kept after done");
  nack_hold_a: assert property (
    nackAll && !(wr && idx == cec_pkg::IDX_LOCK) |=> nackAll) else $error("lock dropped by itself");
endmodule : cec_buffer_addr_wakeup_checker

bind cec_buffer_addr_wakeup cec_buffer_addr_wakeup_checker cec_buffer_addr_wakeup_checker_i (
  .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .nackAll(nackAll), .ownedAddr(ownedAddr),
  .txStart(txStart), .txLength(txLength), .txDone(txDone));

/* verif/cec_line_engine_model.sv */
`timescale 1ns/1ps
// ****************
// far-side line engine
// ****************
module cec_line_engine_model (
  input wire logic            core_clk,
  input wire logic            rxReady,
  input wire logic            nackAll,
  input wire logic            txStart,
  input wire logic [4:0]      txLength,
  input wire logic [7:0]      txByte,
  output logic                rxValid,
  output cec_pkg::rx_item_type rxItem,
  output logic [3:0]          txIndex,
  output logic                txDone
);
  logic [7:0] txSeen [$];
  logic       sawNack;
  int         gap;
  // quiet start
  initial begin
    rxValid = 1'b0;
    rxItem = '0;
    txIndex = 4'h0;
    txDone = 1'b0;
    gap = 0;
  end
  // hand a frame over, each byte held until taken
  task automatic send_frame(input logic [7:0] b [$], input logic good);
    sawNack = nackAll;
    for (int i = 0; i < b.size(); i++) begin
      rxValid <= 1'b1;
      rxItem <= '{b[i], i == b.size() - 1, good};
      do @(posedge core_clk); while (rxReady !== 1'b1);
    end
    rxValid <= 1'b0;
    rxItem <= ~rxItem; // stale data must not look valid
  endtask : send_frame
  // serve a transmit: fetch every byte, then pulse done
  always begin
    @(posedge core_clk);
    if (txStart === 1'b1) begin
      for (int i = 0; i < txLength; i++) begin
        txIndex <= i[3:0];
        @(posedge core_clk);
        @(posedge core_clk);
        txSeen.push_back(txByte);
      end
      repeat (gap) @(posedge core_clk);
      txDone <= 1'b1;
      @(posedge core_clk);
      txDone <= 1'b0;
      txIndex <= ~txIndex;
      @(posedge core_clk);
    end
  end
endmodule : cec_line_engine_model

/* verif/test_cec_buffer_addr_wakeup.sv */
`timescale 1ns/1ps
// ****************
// bench top
// ****************
module test_cec_buffer_addr_wakeup;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, rxValid, rxReady, nackAll, txStart, txDone, wakeEvent, err, w;
  cec_pkg::rx_item_type rxItem;
  logic [15:0] ownedAddr;
  logic [4:0]  txLength;
  logic [3:0]  txIndex;
  logic [7:0]  txByte, en;
  logic [7:0]  txb [16];
  logic [7:0]  fr [$];
  logic [7:0]  frB [$];
  int          bad_count = 0;
  int          n_compared = 0;
  int          seed = 48886;
  // 25 MHz clock
  always #20 core_clk = ~core_clk;
  cec_buffer_addr_wakeup #(.FIFO_DEPTH(8)) cec_buffer_addr_wakeup_i (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxValid(rxValid), .rxReady(rxReady), .rxItem(rxItem), .nackAll(nackAll), .ownedAddr(ownedAddr),
    .txStart(txStart), .txLength(txLength), .txIndex(txIndex), .txByte(txByte), .txDone(txDone),
    .wakeEvent(wakeEvent));
  cec_line_engine_model cec_line_engine_model_i (
    .core_clk(core_clk), .rxReady(rxReady), .nackAll(nackAll), .txStart(txStart), .txLength(txLength),
    .txByte(txByte), .rxValid(rxValid), .rxItem(rxItem), .txIndex(txIndex), .txDone(txDone));
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic conclude();
    if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp
  // one apb transfer; the idle edge first keeps strobes single-driven
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // no assumed wait count; only the watchdog cuts a missing answer short
    do @(posedge core_clk); while (pready !== 1'b1);
    cmp("pready", 32'h1, pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input string name, input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, rnd());
    cmp(name, exp, rd);
  endtask : rchk
  // cut a hang short
  initial begin
    #2000000;
    bad_count++;
    conclude();
  end
  // main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    cmp("ownedAddr", 32'h8000, ownedAddr);
    rchk("addrHigh", cec_pkg::IDX_ADDR_HI, 32'h80);
    rchk("txLen", cec_pkg::IDX_TX_LEN, 32'h0);
    rchk("wakeEn", cec_pkg::IDX_WAKE_EN, 32'hff);
    rchk("lock", cec_pkg::IDX_LOCK, 32'h0);
    rchk("rxBuf", cec_pkg::IDX_RX_BUF, 32'h0);
    rchk("unmapped", 16'h7d03, 32'h0);
    cmp("slverr", 32'h1, err);
    apb(1'b1, cec_pkg::IDX_RX_LEN, 32'h5);
    rchk("rxLenRo", cec_pkg::IDX_RX_LEN, 32'h0);
    for (int k = 0; k < 4; k++) begin
      en = 8'(rnd());
      apb(1'b1, cec_pkg::IDX_ADDR_LOW, en);
      apb(1'b1, cec_pkg::IDX_ADDR_HI, ~en);
      // map output is one flop behind the register, seen two edges after the write
      repeat (2) @(posedge core_clk);
      cmp("ownedAddr", {~en, en}, ownedAddr);
    end
    for (int i = 0; i < 16; i++) begin
      txb[i] = 8'(rnd());
      apb(1'b1, 16'(cec_pkg::IDX_TX_BUF + i), txb[i]);
    end
    for (int i = 0; i < 16; i++) rchk("txBuf", 16'(cec_pkg::IDX_TX_BUF + i), txb[i]);
    apb(1'b1, cec_pkg::IDX_CTRL, 32'h1);
    rchk("sendIgnored", cec_pkg::IDX_CTRL, 32'h0);
    // longest frame with slow done, then shortest with prompt done
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, cec_pkg::IDX_TX_LEN, k ? 32'h1 : 32'h14);
      rchk("txLen", cec_pkg::IDX_TX_LEN, k ? 32'h1 : 32'h10);
      cec_line_engine_model_i.gap = 3 - 3 * k;
      cec_line_engine_model_i.txSeen.delete();
      apb(1'b1, cec_pkg::IDX_CTRL, 32'h1);
      repeat (2) @(posedge core_clk);
      for (int n = 0; n < 80 && txStart !== 1'b0; n++) @(posedge core_clk);
      rchk("send", cec_pkg::IDX_CTRL, 32'h0);
      rchk("txLenKept", cec_pkg::IDX_TX_LEN, k ? 32'h1 : 32'h10);
      cmp("txCount", k ? 32'h1 : 32'h10, cec_line_engine_model_i.txSeen.size());
      for (int i = 0; i < (k ? 1 : 16); i++) cmp("txByte", txb[i], cec_line_engine_model_i.txSeen[i]);
    end
    en = 8'(rnd());
    apb(1'b1, cec_pkg::IDX_WAKE_EN, en);
    // every wake opcode, then one that never wakes
    for (int k = 0; k < 9; k++) begin
      fr = '{8'(rnd()), k < 8 ? cec_pkg::WAKE_OPCODES[k] : 8'h00, 8'(rnd())};
      w = k < 8 && en[k];
      apb(1'b1, cec_pkg::IDX_MASK, {k[0], 6'h0});
      cec_line_engine_model_i.send_frame(fr, 1'b1);
      repeat (4) @(posedge core_clk);
      cmp("sawNack", 32'h0, cec_line_engine_model_i.sawNack);
      rchk("rxLen", cec_pkg::IDX_RX_LEN, 32'h3);
      for (int i = 0; i < 3; i++) rchk("rxBuf", 16'(cec_pkg::IDX_RX_BUF + i), fr[i]);
      rchk("lock", cec_pkg::IDX_LOCK, 32'h1);
      apb(1'b0, cec_pkg::IDX_STATUS, 32'h0);
      cmp("wake", w, rd[6]);
      cmp("wakeEvent", w && !k[0], wakeEvent);
      if (k < 8) apb(1'b1, cec_pkg::IDX_LOCK, 32'h0);
    end
    // locked: fifo fills and refuses, stored frame stays intact
    for (int i = 0; i < 10; i++) frB.push_back(8'(rnd()));
    fork
      cec_line_engine_model_i.send_frame(frB, 1'b1);
    join_none
    repeat (14) @(posedge core_clk);
    cmp("rxReady", 32'h0, rxReady);
    cmp("sawNack", 32'h1, cec_line_engine_model_i.sawNack);
    rchk("rxLenHeld", cec_pkg::IDX_RX_LEN, 32'h3);
    rchk("rxBufHeld", cec_pkg::IDX_RX_BUF, fr[0]);
    apb(1'b1, cec_pkg::IDX_LOCK, 32'h0);
    wait fork;
    // queued bytes, at most the fifo depth of eight, still drain one per cycle after the last push
    repeat (8) @(posedge core_clk);
    rchk("rxLen", cec_pkg::IDX_RX_LEN, 32'ha);
    for (int i = 0; i < 10; i++) rchk("rxBuf", 16'(cec_pkg::IDX_RX_BUF + i), frB[i]);
    apb(1'b1, cec_pkg::IDX_LOCK, 32'h0);
    cec_line_engine_model_i.send_frame(fr, 1'b0);
    repeat (4) @(posedge core_clk);
    rchk("rxLenBad", cec_pkg::IDX_RX_LEN, 32'ha);
    rchk("lockBad", cec_pkg::IDX_LOCK, 32'h0);
    conclude();
  end
endmodule : test_cec_buffer_addr_wakeup
